// ===== src/sckc_pkg.sv
package sckc_pkg;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'hD8;
  localparam int         BIT_SLOW_TYPE      = 7;
  localparam int         BIT_FAST_TYPE      = 6;
  localparam int         BIT_SLOW_STOP      = 5;
  localparam int         BIT_PERIPH_STOP    = 4;
  localparam int         BIT_FAST_STOP      = 3;
  localparam int         BIT_FAST_SELECT    = 2;
  localparam int         PSC_HI             = 1;
  localparam int         PSC_LO             = 0;
  localparam logic [7:0] CLOCK_CONTROL_RST  = 8'h23;
  localparam logic [1:0] PSC_DIV16          = 2'h0;
  localparam logic [1:0] PSC_DIV4           = 2'h1;
  localparam logic [1:0] PSC_DIV2           = 2'h2;
  localparam logic [1:0] PSC_DIV1           = 2'h3;
  localparam int         PSC_SETTLE_CYCLES  = 16;
  localparam int         DIV_WIDTH          = 4;
endpackage

// ===== src/sckc_divider.sv
`timescale 1ns/1ps
module sckc_divider #(
  parameter int WIDTH = sckc_pkg::DIV_WIDTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_ce,
  input  wire logic [1:0]       i_code,
  output logic                  o_tick,
  output logic [WIDTH-1:0]      o_count
);
  // Masks reach 4 bits for the divide-by-16 code
  if (WIDTH < 4) begin : g_width_check
    $error("sckc_divider needs WIDTH of at least 4");
  end

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] mask;
  logic             wrap;

  // Terminal mask per code; a new code acts at once on the running count, so <=16 cycles
  assign mask = (i_code == sckc_pkg::PSC_DIV16) ? WIDTH'(4'hF) :
                (i_code == sckc_pkg::PSC_DIV4)  ? WIDTH'(4'h3) :
                (i_code == sckc_pkg::PSC_DIV2)  ? WIDTH'(4'h1) :
                                                  WIDTH'(4'h0);
  assign wrap = ((cnt_ff & mask) == mask);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ff <= '0;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      cnt_ff <= wrap ? '0 : cnt_ff + WIDTH'(1);
      o_tick <= wrap;
    end
  end

  assign o_count = cnt_ff;
endmodule

// ===== src/sckc_top.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module sckc_top (
  input  wire logic       I_CLK,
  input  wire logic       I_RESETN,
  input  wire logic       I_CE,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic       I_POWER_DOWN_BIT,
  input  wire logic       I_IDLE,
  input  wire logic       I_SLOW_MODE,
  output logic [7:0]      O_RDATA,
  output logic            O_SLOW_CRYSTAL_EN,
  output logic            O_SLOW_INTERNAL_OSCILLATOR_EN,
  output logic            O_FAST_CRYSTAL_EN,
  output logic            O_FAST_INTERNAL_OSCILLATOR_EN,
  output logic            O_FAST_HIGH_GAIN,
  output logic            O_CRYSTAL_PINS,
  output logic            O_FAST_SELECT,
  output logic            O_SYS_TICK,
  output logic            O_PERIPH_CLK_EN
);
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic       hit;
  logic       wr_hit;
  logic       fast_mode;
  logic       slow_mode;
  logic       fast_stopped;
  logic       tick;
  logic [3:0] div_cnt;

  assign hit          = (I_ADDR == sckc_pkg::ADDR_CLOCK_CONTROL);
  assign wr_hit       = I_WR & hit;
  assign fast_mode    = ctl_ff[sckc_pkg::BIT_FAST_SELECT];
  assign slow_mode    = ~fast_mode;
  assign fast_stopped = ctl_ff[sckc_pkg::BIT_FAST_STOP];

  // Each guarded bit judged against the old register value
  always_comb begin
    nxt_ctl = ctl_ff;
    if (wr_hit) begin
      nxt_ctl[sckc_pkg::BIT_SLOW_STOP]   = I_WDATA[sckc_pkg::BIT_SLOW_STOP];
      nxt_ctl[sckc_pkg::BIT_PERIPH_STOP] =
        I_WDATA[sckc_pkg::BIT_PERIPH_STOP];
      nxt_ctl[sckc_pkg::PSC_HI:sckc_pkg::PSC_LO] =
        I_WDATA[sckc_pkg::PSC_HI:sckc_pkg::PSC_LO];
      if (fast_mode) begin
        nxt_ctl[sckc_pkg::BIT_SLOW_TYPE] = I_WDATA[sckc_pkg::BIT_SLOW_TYPE];
      end
      if (slow_mode) begin
        nxt_ctl[sckc_pkg::BIT_FAST_TYPE] = I_WDATA[sckc_pkg::BIT_FAST_TYPE];
        nxt_ctl[sckc_pkg::BIT_FAST_STOP] = I_WDATA[sckc_pkg::BIT_FAST_STOP];
      end
      if (!fast_stopped) begin
        nxt_ctl[sckc_pkg::BIT_FAST_SELECT] =
          I_WDATA[sckc_pkg::BIT_FAST_SELECT];
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctl_ff <= sckc_pkg::CLOCK_CONTROL_RST;
    end else if (I_CE) begin
      ctl_ff <= nxt_ctl;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RDATA <= 8'h00;
    end else if (I_CE) begin
      O_RDATA <= (I_RD & hit) ? ctl_ff : 8'h00;
    end
  end

  sckc_divider #(
    .WIDTH (sckc_pkg::DIV_WIDTH)
  ) u_div (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_ce     (I_CE),
    .i_code   (ctl_ff[sckc_pkg::PSC_HI:sckc_pkg::PSC_LO]),
    .o_tick   (tick),
    .o_count  (div_cnt)
  );

  logic slow_type;
  logic fast_type;
  logic slow_run;
  logic fast_run;
  assign slow_type = ctl_ff[sckc_pkg::BIT_SLOW_TYPE];
  assign fast_type = ctl_ff[sckc_pkg::BIT_FAST_TYPE];
  // Slow clock stops only when powered down with slow_stop set
  assign slow_run = ~(ctl_ff[sckc_pkg::BIT_SLOW_STOP] & I_POWER_DOWN_BIT);
  // Fast clock stopped by power-down even while selected; stop bit needs slow mode
  assign fast_run = ~(fast_stopped & slow_mode &
                      (I_SLOW_MODE | I_IDLE)) & ~I_POWER_DOWN_BIT;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SLOW_CRYSTAL_EN             <= 1'b0;
      O_SLOW_INTERNAL_OSCILLATOR_EN <= 1'b1;
      O_FAST_CRYSTAL_EN             <= 1'b0;
      O_FAST_INTERNAL_OSCILLATOR_EN <= 1'b1;
      O_FAST_HIGH_GAIN              <= 1'b0;
      O_CRYSTAL_PINS                <= 1'b0;
      O_FAST_SELECT                 <= 1'b0;
      O_SYS_TICK                    <= 1'b0;
      O_PERIPH_CLK_EN               <= 1'b1;
    end else if (I_CE) begin
      O_SLOW_CRYSTAL_EN             <= slow_type & slow_run;
      O_SLOW_INTERNAL_OSCILLATOR_EN <= ~slow_type & slow_run;
      O_FAST_CRYSTAL_EN             <= fast_type & fast_run;
      O_FAST_INTERNAL_OSCILLATOR_EN <= ~fast_type & fast_run;
      O_FAST_HIGH_GAIN              <= fast_type;
      O_CRYSTAL_PINS                <= slow_type | fast_type;
      O_FAST_SELECT                 <= fast_mode;
      O_SYS_TICK                    <= tick;
      O_PERIPH_CLK_EN               <= ~(ctl_ff[sckc_pkg::BIT_PERIPH_STOP]
                                         & I_IDLE);
    end
  end

  // Assertions
  property p_slow_type_guard;
    @(posedge I_CLK) disable iff (!I_RESETN)
    (I_CE && !fast_mode) |=> $stable(slow_type);
  endproperty
  a_slow_type_guard: assert property (p_slow_type_guard)
    else $error("slow type changed outside fast mode");

  property p_fast_type_guard;
    @(posedge I_CLK) disable iff (!I_RESETN)
    (I_CE && fast_mode) |=> $stable(fast_type) && $stable(fast_stopped);
  endproperty
  a_fast_type_guard: assert property (p_fast_type_guard)
    else $error("fast bits changed outside slow mode");

  property p_select_guard;
    @(posedge I_CLK) disable iff (!I_RESETN)
    (I_CE && fast_stopped) |=> $stable(fast_mode);
  endproperty
  a_select_guard: assert property (p_select_guard)
    else $error("select changed while fast stopped");

  property p_slow_halt;
    @(posedge I_CLK) disable iff (!I_RESETN)
    (I_CE && ctl_ff[sckc_pkg::BIT_SLOW_STOP] && I_POWER_DOWN_BIT)
      |=> !O_SLOW_CRYSTAL_EN && !O_SLOW_INTERNAL_OSCILLATOR_EN;
  endproperty
  a_slow_halt: assert property (p_slow_halt)
    else $error("slow clock runs after power-down");

  property p_periph_gate;
    @(posedge I_CLK) disable iff (!I_RESETN)
    (I_CE && ctl_ff[sckc_pkg::BIT_PERIPH_STOP] && I_IDLE)
      |=> !O_PERIPH_CLK_EN;
  endproperty
  a_periph_gate: assert property (p_periph_gate)
    else $error("peripheral clock not gated in idle");

  property p_crystal_pins;
    @(posedge I_CLK) disable iff (!I_RESETN)
    (I_CE && slow_type) |=> O_CRYSTAL_PINS;
  endproperty
  a_crystal_pins: assert property (p_crystal_pins)
    else $error("crystal pins not claimed");

  property p_high_gain;
    @(posedge I_CLK) disable iff (!I_RESETN)
    (I_CE && fast_type) |=> O_FAST_HIGH_GAIN && O_CRYSTAL_PINS;
  endproperty
  a_high_gain: assert property (p_high_gain)
    else $error("fast crystal gain not high");

  property p_div1_every;
    @(posedge I_CLK) disable iff (!I_RESETN)
    (I_CE && div_cnt == 4'h0 &&
     ctl_ff[sckc_pkg::PSC_HI:sckc_pkg::PSC_LO] == sckc_pkg::PSC_DIV1)
      |=> tick;
  endproperty
  a_div1_every: assert property (p_div1_every)
    else $error("divide by one missed a tick");

  property p_psc_settle;
    @(posedge I_CLK) disable iff (!I_RESETN)
    (wr_hit && I_CE) |-> ##[1:16] (tick || !I_CE);
  endproperty
  a_psc_settle: assert property (p_psc_settle)
    else $error("prescaler not in effect within 16 cycles");

  property p_fast_stop_gate;
    @(posedge I_CLK) disable iff (!I_RESETN)
    (I_CE && fast_stopped && slow_mode && (I_SLOW_MODE || I_IDLE))
      |=> !O_FAST_CRYSTAL_EN && !O_FAST_INTERNAL_OSCILLATOR_EN;
  endproperty
  a_fast_stop_gate: assert property (p_fast_stop_gate)
    else $error("fast clock runs while stopped");

  property p_select_track;
    @(posedge I_CLK) disable iff (!I_RESETN)
    I_CE |=> (O_FAST_SELECT == $past(fast_mode));
  endproperty
  a_select_track: assert property (p_select_track)
    else $error("select output lags the register");

  // Bus stays quiet except in the cycle after a mapped read
  property p_rdata_idle;
    @(posedge I_CLK) disable iff (!I_RESETN)
    (I_CE && !(I_RD && hit)) |=> (O_RDATA == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  c_fast_mode: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
    $rose(fast_mode));
  c_fast_stop: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
    $rose(fast_stopped));
  c_div16: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
    tick && ctl_ff[sckc_pkg::PSC_HI:sckc_pkg::PSC_LO] == sckc_pkg::PSC_DIV16);
  c_idle_gate: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
    $fell(O_PERIPH_CLK_EN));
endmodule

// ===== tb/sckc_top_bench.sv
`timescale 1ns/1ps
module sckc_top_bench;
  logic       clk;
  logic       rst_n;
  logic       ce;
  logic [7:0] outs;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       pdown;
  logic       idle_md;
  logic       slow_md;
  logic [7:0] rdata;
  logic       sxt_en;
  logic       src_en;
  logic       fxt_en;
  logic       frc_en;
  logic       gain;
  logic       xpins;
  logic       fsel;
  logic       tick;
  logic       pclk_en;
  int         n_fail;
  int         n_checks;
  int         cyc;
  int         cnt;
  sckc_top u_dut (
    .I_CLK                         (clk),
    .I_RESETN                      (rst_n),
    .I_CE                          (ce),
    .I_ADDR                        (addr),
    .I_WDATA                       (wdata),
    .I_WR                          (wr),
    .I_RD                          (rd),
    .I_POWER_DOWN_BIT              (pdown),
    .I_IDLE                        (idle_md),
    .I_SLOW_MODE                   (slow_md),
    .O_RDATA                       (rdata),
    .O_SLOW_CRYSTAL_EN             (sxt_en),
    .O_SLOW_INTERNAL_OSCILLATOR_EN (src_en),
    .O_FAST_CRYSTAL_EN             (fxt_en),
    .O_FAST_INTERNAL_OSCILLATOR_EN (frc_en),
    .O_FAST_HIGH_GAIN              (gain),
    .O_CRYSTAL_PINS                (xpins),
    .O_FAST_SELECT                 (fsel),
    .O_SYS_TICK                    (tick),
    .O_PERIPH_CLK_EN               (pclk_en)
  );
  always #10 clk = ~clk;
  // Select, slow RC, fast RC, slow xtal, fast xtal, gain, pins, periph
  assign outs = {fsel, src_en, frc_en, sxt_en, fxt_en, gain, xpins, pclk_en};
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Limit far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Every drive lands on a rising edge; a gap cycle keeps strobes apart
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task automatic drive_pins(input logic c, input logic p, input logic i,
                            input logic s);
    @(posedge clk);
    ce      <= c;
    pdown   <= p;
    idle_md <= i;
    slow_md <= s;
  endtask
  // Outputs settle one edge after the register; look mid-cycle
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    clk      = 1'b0;
    rst_n    = 1'b0;
    ce       = 1'b1;
    addr     = 8'h00;
    wdata    = 8'h00;
    wr       = 1'b0;
    rd       = 1'b0;
    pdown    = 1'b0;
    idle_md  = 1'b0;
    slow_md  = 1'b0;
    n_fail   = 0;
    n_checks = 0;
    cyc      = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(outs, 8'h61);
    chk(rdata, 8'h00);
    rd_reg(8'hD8, 8'h23);
    $display("Test reset values done");
    wr_reg(8'hD8, 8'h63);
    wait_cyc(2);
    chk(outs, 8'h4F);
    wr_reg(8'hD8, 8'hE3);
    rd_reg(8'hD8, 8'h63);
    $display("Test source types done");
    wr_reg(8'hD8, 8'h6B);
    rd_reg(8'hD8, 8'h6B);
    drive_pins(1'b1, 1'b0, 1'b0, 1'b1);
    wait_cyc(2);
    chk(outs, 8'h47);
    wr_reg(8'hD8, 8'h6F);
    rd_reg(8'hD8, 8'h6B);
    drive_pins(1'b1, 1'b0, 1'b0, 1'b0);
    wr_reg(8'hD8, 8'h63);
    wr_reg(8'hD8, 8'h67);
    wait_cyc(2);
    chk(outs, 8'hCF);
    wr_reg(8'hD8, 8'hE7);
    rd_reg(8'hD8, 8'hE7);
    wait_cyc(2);
    chk(outs, 8'h9F);
    wr_reg(8'hD8, 8'hA7);
    rd_reg(8'hD8, 8'hE7);
    wr_reg(8'hD8, 8'hEF);
    rd_reg(8'hD8, 8'hE7);
    $display("Test guarded writes done");
    wr_reg(8'hD8, 8'hE3);
    drive_pins(1'b1, 1'b1, 1'b0, 1'b0);
    wait_cyc(2);
    chk(outs, 8'h07);
    wr_reg(8'hD8, 8'hC3);
    wait_cyc(2);
    chk(outs, 8'h17);
    drive_pins(1'b1, 1'b0, 1'b1, 1'b0);
    wr_reg(8'hD8, 8'hD3);
    wait_cyc(2);
    chk(outs, 8'h1E);
    wr_reg(8'hD8, 8'hC3);
    wait_cyc(2);
    chk(outs, 8'h1F);
    drive_pins(1'b1, 1'b0, 1'b0, 1'b0);
    $display("Test stop controls done");
    wr_reg(8'hD9, 8'hFF);
    rd_reg(8'hD9, 8'h00);
    rd_reg(8'hD8, 8'hC3);
    $display("Test unmapped done");
    // Mid-run reset, then a write while the enable is low must not land
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(outs, 8'h61);
    rd_reg(8'hD8, 8'h23);
    drive_pins(1'b0, 1'b0, 1'b0, 1'b0);
    wr_reg(8'hD8, 8'h22);
    drive_pins(1'b1, 1'b0, 1'b0, 1'b0);
    rd_reg(8'hD8, 8'h23);
    $display("Test reset and enable done");
    // Ticks in 32 cycles: 32 divided by the ratio of each code
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'hD8, {6'h30, 2'(i)});
      wait_cyc(18);
      cnt = 0;
      repeat (32) begin
        @(negedge clk);
        if (tick === 1'b1) cnt++;
      end
      chk(8'(cnt), (i == 0) ? 8'h02 : 8'h08 << (i - 1));
    end
    $display("Test prescaler done");
    report_and_stop();
  end
endmodule
